// ===== rtl/pcr_map.svh
// Purpose: offsets, field positions, reset values and counts of the
//          phy configuration and indirect access registers
// Assumes: register indices are the management-frame register numbers
// Notes:   included by the package and the register module
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// ----------------------------------------------------------------------
// register indices on the management bus
// ----------------------------------------------------------------------
`define PCR_IDX_LINK_CFG     5'h09
`define PCR_IDX_CMD_SEL      5'h0D
`define PCR_IDX_ADDR_DATA    5'h0E
`define PCR_IDX_IRQ_TEST     5'h11

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCR_CFG_SOFT_RST     15
`define PCR_CFG_TXERR_DIS    14
`define PCR_CFG_AN_EN        13
`define PCR_CFG_ENABLE       12
`define PCR_CFG_REFL_AUTO    8
`define PCR_IRQ_POLARITY     3
`define PCR_IRQ_FORCE        2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PCR_CFG_RST          16'h2000
`define PCR_IRQ_TEST_RST     16'h010B

// ----------------------------------------------------------------------
// indirect command codes and target spaces
// ----------------------------------------------------------------------
`define PCR_CMD_ADDRESS      2'b00
`define PCR_CMD_DATA         2'b01
`define PCR_CMD_INC_RW       2'b10
`define PCR_CMD_INC_WR       2'b11
`define PCR_SPACE_VENDOR     5'b11111
`define PCR_SPACE_PMA        5'b00001
`define PCR_VENDOR_TOP       16'h04D1

// ----------------------------------------------------------------------
// management frame counts
// ----------------------------------------------------------------------
`define PCR_OP_READ          2'b10
`define PCR_OP_WRITE         2'b01
`define PCR_PREAMBLE_BITS    6'd32
`define PCR_HDR_LAST         5'd11
`define PCR_DATA_LAST        5'd15
`define PCR_DATA_BITS        5'd16
`define PCR_SKIP_LAST        5'd17
`define PCR_STRAP_WAIT       2'd2

`endif

// ===== rtl/pcr_pkg.sv
// Purpose: types shared by the configuration register block
// Assumes: constants come from the map header
// Notes:   state is one packed struct registered in one process
`include "pcr_map.svh"

package pcr_pkg;

    // ------------------------------------------------------------------
    // management frame receiver states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MS_IDLE,
        MS_START,
        MS_HDR,
        MS_WTA,
        MS_WDAT,
        MS_RTA,
        MS_RDAT,
        MS_SKIP
    } pcr_mdio_st_t;

    // serial mac link controls handed to the interface logic
    typedef struct packed {
        logic softRst;
        logic txErrDis;
        logic anEn;
        logic enable;
        logic reflAutoRun;
    } pcr_link_ctl_t;

    // one indirect access toward the extended register spaces
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pcr_mmd_req_t;

    // the whole state of the register block
    typedef struct packed {
        logic [2:0]   mdcSync;
        logic [1:0]   mdioSync;
        logic [1:0]   strapSync;
        logic [1:0]   strapCnt;
        logic         strapDone;
        pcr_mdio_st_t st;
        logic [4:0]   bitCnt;
        logic [5:0]   ones;
        logic         preOk;
        logic [15:0]  shift;
        logic [4:0]   regAd;
        logic [15:0]  linkCfg;
        logic [1:0]   cmd;
        logic [4:0]   space;
        logic [15:0]  addrVendor;
        logic [15:0]  addrPma;
        logic [15:0]  irqTest;
        pcr_mmd_req_t mmd;
        logic         rdPend;
        logic         rdHit;
        logic [15:0]  mmdData;
        logic         linkPrev;
        logic         reflStart;
        logic         intPin;
        logic         mdioOut;
        logic         mdioOen;
    } pcr_state_t;

endpackage

// ===== rtl/pcr_phy_config_regs.sv
// Purpose: serial mac link, reflectometry, indirect access and interrupt
//          pin control registers behind the management serial bus
// Assumes: mdc is far slower than mclk; phyAddr and irqEvent and linkUp
//          come from logic on mclk; mmdRdata is valid one cycle after rd
// Notes:   mdio output enable is low while this block drives the line
`include "pcr_map.svh"
module pcr_phy_config_regs (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   mdc,
    input  wire logic                   mdioIn,
    output logic                        mdioOut,
    output logic                        mdioOen,
    input  wire logic [4:0]             phyAddr,
    input  wire logic                   linkEnStrap,
    input  wire logic                   linkUp,
    input  wire logic                   irqEvent,
    output logic                        intPin,
    output logic                        reflStart,
    output pcr_pkg::pcr_link_ctl_t      linkCtl,
    output pcr_pkg::pcr_mmd_req_t       mmdReq,
    input  wire logic [15:0]            mmdRdata
);
    import pcr_pkg::*;

    pcr_state_t s_r;
    pcr_state_t s_nxt;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    // only two spaces answer; anything else must leave state untouched
    function automatic logic spaceOk(input logic [4:0] sp);
        spaceOk = (sp == `PCR_SPACE_VENDOR) || (sp == `PCR_SPACE_PMA);
    endfunction

    // vendor space stops at its top register, pma space is full width
    function automatic logic addrOk(input logic [4:0]  sp,
                                    input logic [15:0] ad);
        addrOk = spaceOk(sp) &&
                 ((sp != `PCR_SPACE_VENDOR) || (ad <= `PCR_VENDOR_TOP));
    endfunction

    logic [15:0] curAddr;
    logic [15:0] readVal;
    logic [11:0] hdr;
    logic [15:0] wrData;
    logic        mdcRise;
    logic        bitIn;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt   = s_r;
        hdr     = {s_r.shift[10:0], s_r.mdioSync[1]};
        wrData  = {s_r.shift[14:0], s_r.mdioSync[1]};
        mdcRise = s_r.mdcSync[1] & ~s_r.mdcSync[2];
        bitIn   = s_r.mdioSync[1];
        curAddr = (s_r.space == `PCR_SPACE_VENDOR) ? s_r.addrVendor
                                                   : s_r.addrPma;

        // read data mux; reserved command bits read as zero
        if (s_r.regAd == `PCR_IDX_LINK_CFG) begin
            readVal = s_r.linkCfg;
        end else if (s_r.regAd == `PCR_IDX_CMD_SEL) begin
            readVal = {s_r.cmd, 9'h000, s_r.space};
        end else if (s_r.regAd == `PCR_IDX_ADDR_DATA) begin
            if (!spaceOk(s_r.space)) begin
                readVal = 16'h0000;
            end else if (s_r.cmd == `PCR_CMD_ADDRESS) begin
                readVal = curAddr;
            end else begin
                readVal = s_r.rdHit ? s_r.mmdData : 16'h0000;
            end
        end else if (s_r.regAd == `PCR_IDX_IRQ_TEST) begin
            readVal = s_r.irqTest;
        end else begin
            readVal = 16'h0000;
        end

        // pins pass two flops, mdc a third for its edge; first stage feeds only the second
        s_nxt.mdcSync   = {s_r.mdcSync[1:0], mdc};
        s_nxt.mdioSync  = {s_r.mdioSync[0], mdioIn};
        s_nxt.strapSync = {s_r.strapSync[0], linkEnStrap};

        // strobes last one cycle
        s_nxt.mmd.rd    = 1'b0;
        s_nxt.mmd.wr    = 1'b0;
        s_nxt.linkCfg[`PCR_CFG_SOFT_RST] = 1'b0;

        // strap caught once the synchroniser has settled after reset
        if (!s_r.strapDone) begin
            if (s_r.strapCnt == `PCR_STRAP_WAIT) begin
                s_nxt.linkCfg[`PCR_CFG_ENABLE] = s_r.strapSync[1];
                s_nxt.strapDone = 1'b1;
            end else begin
                s_nxt.strapCnt = s_r.strapCnt + 2'd1;
            end
        end

        // indirect read data arrives the cycle after the request
        s_nxt.rdPend = s_r.mmd.rd;
        if (s_r.rdPend) begin
            s_nxt.mmdData = mmdRdata;
        end

        // reflectometry start on a falling link when auto-run is set
        s_nxt.linkPrev  = linkUp;
        s_nxt.reflStart = s_r.linkCfg[`PCR_CFG_REFL_AUTO] &
                          s_r.linkPrev & ~linkUp;

        // forced interrupt ored with real events, then polarity
        if (s_r.irqTest[`PCR_IRQ_POLARITY]) begin
            s_nxt.intPin = ~(irqEvent |
                             s_r.irqTest[`PCR_IRQ_FORCE]);
        end else begin
            s_nxt.intPin = irqEvent |
                           s_r.irqTest[`PCR_IRQ_FORCE];
        end

        // management frame bit engine, one step per mdc rising edge
        if (mdcRise) begin
            case (s_r.st)
                MS_IDLE: begin
                    if (bitIn) begin
                        if (s_r.ones != `PCR_PREAMBLE_BITS) begin
                            s_nxt.ones = s_r.ones + 6'd1;
                        end
                        if (s_r.ones == `PCR_PREAMBLE_BITS - 6'd1) begin
                            s_nxt.preOk = 1'b1;
                        end
                    end else begin
                        s_nxt.ones = 6'd0;
                        if (s_r.preOk) begin
                            s_nxt.st = MS_START;
                        end
                    end
                end
                MS_START: begin
                    s_nxt.bitCnt = 5'd0;
                    s_nxt.st     = bitIn ? MS_HDR : MS_IDLE;
                end
                MS_HDR: begin
                    s_nxt.shift  = {s_r.shift[14:0], bitIn};
                    s_nxt.bitCnt = s_r.bitCnt + 5'd1;
                    if (s_r.bitCnt == `PCR_HDR_LAST) begin
                        s_nxt.regAd  = hdr[4:0];
                        s_nxt.bitCnt = 5'd0;
                        if (hdr[11:10] != `PCR_OP_READ &&
                            hdr[11:10] != `PCR_OP_WRITE) begin
                            // bad opcode: demand a full preamble again
                            s_nxt.preOk = 1'b0;
                            s_nxt.st    = MS_IDLE;
                        end else if (hdr[9:5] != phyAddr) begin
                            s_nxt.st = MS_SKIP;
                        end else if (hdr[11:10] == `PCR_OP_WRITE) begin
                            s_nxt.st = MS_WTA;
                        end else begin
                            s_nxt.st    = MS_RTA;
                            s_nxt.rdHit = 1'b0;
                            if (hdr[4:0] == `PCR_IDX_ADDR_DATA &&
                                s_r.cmd != `PCR_CMD_ADDRESS &&
                                addrOk(s_r.space, curAddr)) begin
                                s_nxt.rdHit     = 1'b1;
                                s_nxt.mmd.rd    = 1'b1;
                                s_nxt.mmd.space = s_r.space;
                                s_nxt.mmd.addr  = curAddr;
                                if (s_r.cmd == `PCR_CMD_INC_RW) begin
                                    if (s_r.space == `PCR_SPACE_VENDOR) begin
                                        s_nxt.addrVendor = curAddr + 16'd1;
                                    end else begin
                                        s_nxt.addrPma = curAddr + 16'd1;
                                    end
                                end
                            end
                        end
                    end
                end
                MS_WTA: begin
                    s_nxt.bitCnt = s_r.bitCnt + 5'd1;
                    if ((s_r.bitCnt == 5'd0 && !bitIn) ||
                        (s_r.bitCnt == 5'd1 && bitIn)) begin
                        s_nxt.preOk = 1'b0;
                        s_nxt.st    = MS_IDLE;
                    end else if (s_r.bitCnt == 5'd1) begin
                        s_nxt.bitCnt = 5'd0;
                        s_nxt.st     = MS_WDAT;
                    end
                end
                MS_WDAT: begin
                    s_nxt.shift  = wrData;
                    s_nxt.bitCnt = s_r.bitCnt + 5'd1;
                    if (s_r.bitCnt == `PCR_DATA_LAST) begin
                        s_nxt.st = MS_IDLE;
                        // commit the completed write
                        if (s_r.regAd == `PCR_IDX_LINK_CFG) begin
                            s_nxt.linkCfg = wrData;
                        end else if (s_r.regAd == `PCR_IDX_CMD_SEL) begin
                            s_nxt.cmd   = wrData[15:14];
                            s_nxt.space = wrData[4:0];
                        end else if (s_r.regAd == `PCR_IDX_ADDR_DATA) begin
                            if (!spaceOk(s_r.space)) begin
                                s_nxt.st = MS_IDLE;
                            end else if (s_r.cmd == `PCR_CMD_ADDRESS) begin
                                if (s_r.space == `PCR_SPACE_VENDOR) begin
                                    s_nxt.addrVendor = wrData;
                                end else begin
                                    s_nxt.addrPma = wrData;
                                end
                            end else if (addrOk(s_r.space, curAddr)) begin
                                s_nxt.mmd.wr    = 1'b1;
                                s_nxt.mmd.space = s_r.space;
                                s_nxt.mmd.addr  = curAddr;
                                s_nxt.mmd.wdata = wrData;
                                // both increment codes step on writes
                                if (s_r.cmd[1]) begin
                                    if (s_r.space == `PCR_SPACE_VENDOR) begin
                                        s_nxt.addrVendor = curAddr + 16'd1;
                                    end else begin
                                        s_nxt.addrPma = curAddr + 16'd1;
                                    end
                                end
                            end
                        end else if (s_r.regAd == `PCR_IDX_IRQ_TEST) begin
                            s_nxt.irqTest = wrData;
                        end
                    end
                end
                MS_RTA: begin
                    // second turnaround bit is driven low by us
                    s_nxt.mdioOen = 1'b0;
                    s_nxt.mdioOut = 1'b0;
                    s_nxt.shift   = readVal;
                    s_nxt.bitCnt  = 5'd0;
                    s_nxt.st      = MS_RDAT;
                end
                MS_RDAT: begin
                    if (s_r.bitCnt == `PCR_DATA_BITS) begin
                        s_nxt.mdioOen = 1'b1;
                        s_nxt.mdioOut = 1'b1;
                        s_nxt.st      = MS_IDLE;
                    end else begin
                        s_nxt.mdioOut = s_r.shift[15];
                        s_nxt.shift   = {s_r.shift[14:0], 1'b0};
                        s_nxt.bitCnt  = s_r.bitCnt + 5'd1;
                    end
                end
                MS_SKIP: begin
                    // frame for another address: sit out its tail
                    s_nxt.bitCnt = s_r.bitCnt + 5'd1;
                    if (s_r.bitCnt == `PCR_SKIP_LAST) begin
                        s_nxt.st = MS_IDLE;
                    end
                end
                default: begin
                    s_nxt.st = MS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_r         <= '0;
            s_r.st      <= MS_IDLE;
            s_r.linkCfg <= `PCR_CFG_RST;
            s_r.irqTest <= `PCR_IRQ_TEST_RST;
            s_r.intPin  <= 1'b1;
            s_r.mdioOut <= 1'b1;
            s_r.mdioOen <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign mdioOut   = s_r.mdioOut;
    assign mdioOen   = s_r.mdioOen;
    assign intPin    = s_r.intPin;
    assign reflStart = s_r.reflStart;
    assign mmdReq    = s_r.mmd;
    assign linkCtl.softRst     = s_r.linkCfg[`PCR_CFG_SOFT_RST];
    assign linkCtl.txErrDis    = s_r.linkCfg[`PCR_CFG_TXERR_DIS];
    assign linkCtl.anEn        = s_r.linkCfg[`PCR_CFG_AN_EN];
    assign linkCtl.enable      = s_r.linkCfg[`PCR_CFG_ENABLE];
    assign linkCtl.reflAutoRun = s_r.linkCfg[`PCR_CFG_REFL_AUTO];

endmodule

// ===== tb/pcr_phy_config_regs_monitor.sv
// Purpose: port checks of the configuration register block
// Assumes: one clock, synchronous active high reset
// Notes:   bound to the block below the module
`include "pcr_map.svh"
module pcr_monitor (
    input logic                   mclk,
    input logic                   rst,
    input logic                   mdioOut,
    input logic                   mdioOen,
    input logic                   linkUp,
    input logic                   intPin,
    input logic                   reflStart,
    input pcr_pkg::pcr_link_ctl_t linkCtl,
    input pcr_pkg::pcr_mmd_req_t  mmdReq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pcr_pkg::*;
    logic req;
    // ------------------------------------------------------------
    // output relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // any indirect request, read or write
    assign req = mmdReq.rd || mmdReq.wr;
    soft_rst_pulse_a: assert property (
        linkCtl.softRst |=> !linkCtl.softRst)
        else $error("soft reset pulse longer than one cycle");
    reset_defaults_a: assert property (
        $fell(rst) |-> linkCtl.anEn && !linkCtl.txErrDis && intPin)
        else $error("wrong control levels after reset");
    refl_on_drop_a: assert property (
        $fell(linkUp) && linkCtl.reflAutoRun |-> ##[1:3] reflStart)
        else $error("no reflectometry start on link loss");
    // cause is judged one cycle back: the pulse is registered
    refl_needs_auto_a: assert property (
        reflStart |-> $past(linkCtl.reflAutoRun) && !$past(linkUp)
                      && $past(linkUp, 2))
        else $error("reflectometry started without cause");
    req_pulse_a: assert property (
        req |=> !req)
        else $error("indirect request longer than one cycle");
    space_valid_a: assert property (
        req |-> mmdReq.space inside {`PCR_SPACE_VENDOR, `PCR_SPACE_PMA})
        else $error("request toward an ignored space");
    vendor_top_a: assert property (
        req && mmdReq.space == `PCR_SPACE_VENDOR
        |-> mmdReq.addr <= `PCR_VENDOR_TOP)
        else $error("vendor request above the top address");
    turnaround_low_a: assert property (
        $fell(mdioOen) |-> !mdioOut)
        else $error("read turnaround not driven low");
    // main scenarios reached
    cover property (linkCtl.softRst);
    cover property (reflStart);
    cover property (mmdReq.rd);
    cover property (mmdReq.wr);
endmodule
bind pcr_phy_config_regs pcr_monitor u_pcr_monitor (
    .mclk(mclk), .rst(rst), .mdioOut(mdioOut), .mdioOen(mdioOen),
    .linkUp(linkUp), .intPin(intPin), .reflStart(reflStart),
    .linkCtl(linkCtl), .mmdReq(mmdReq)
);

// ===== tb/pcr_mdio_master.sv
// Purpose: station management controller model on the mdio line
// Assumes: mdc half period of eight mclk cycles
// Notes:   mdc stands low between frames; a free line is pulled up
`include "pcr_map.svh"
module pcr_mdio_master #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input  logic mclk,
    input  logic mdioOut,
    input  logic mdioOen,
    output logic mdc,
    output logic mdioLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b1;
    logic drvEn = 1'b0;
    // ------------------------------------------------------------
    // line level and frames
    // ------------------------------------------------------------
    // block drives while its enable is low, else master or pull-up
    assign mdioLine = !mdioOen ? mdioOut : (drvEn ? drv : 1'b1);
    initial mdc = 1'b0;
    // one mdc period, line sampled at the rising edge
    task automatic tick(input logic v, input logic en, output logic s);
        drv = v;
        drvEn = en;
        repeat (8) @(posedge mclk);
        #2 mdc = 1'b1;
        s = mdioLine;
        repeat (8) @(posedge mclk);
        #2 mdc = 1'b0;
    endtask
    // full preamble each frame: never caught out after an error
    task automatic frame(input logic rd, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [45:0] hdr;
        logic        s;
        hdr = {32'hFFFF_FFFF, 2'b01, rd ? `PCR_OP_READ : `PCR_OP_WRITE,
               PHY_ADDR, ra};
        for (int i = 45; i >= 0; i--) tick(hdr[i], 1'b1, s);
        tick(1'b1, !rd, s);
        tick(1'b0, !rd, s);
        for (int i = 15; i >= 0; i--) begin
            tick(wd[i], !rd, s);
            q[i] = s;
        end
        drvEn = 1'b0;
    endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the configuration register block
// Assumes: every register access goes through the mdio master model
// Notes:   far side register spaces are modelled by mdat below
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pcr_pkg::*;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          linkUp = 1'b1;
    logic          irqEvent = 1'b0;
    logic          strap = 1'b1;
    logic [15:0]   mmdRdata = 16'h0000;
    logic          mdc, mdioLine, mdioOut, mdioOen, intPin, reflStart;
    pcr_link_ctl_t linkCtl;
    pcr_mmd_req_t  mmdReq;
    logic [15:0]   rdAddr, wrAddr, wrData, a;
    logic [4:0]    reqSp;
    int            n_errors = 0;
    int            compares = 0;
    int            nReq = 0;
    int            nSoft = 0;
    int            nRefl = 0;
    localparam logic [4:0]  SP [5] = '{5'h01, 5'h1F, 5'h1F, 5'h1F, 5'h02};
    localparam logic [15:0] AD [5] = '{16'h0010, 16'h0100, 16'h04D0,
                                       16'h04D2, 16'h0040};
    localparam logic [1:0]  CM [5] = '{2'b01, 2'b10, 2'b11, 2'b01, 2'b01};
    always #12.5 mclk = ~mclk;
    pcr_phy_config_regs u_pcr_phy_config_regs (
        .mclk(mclk), .rst(rst), .mdc(mdc), .mdioIn(mdioLine),
        .mdioOut(mdioOut), .mdioOen(mdioOen), .phyAddr(5'h03),
        .linkEnStrap(strap), .linkUp(linkUp), .irqEvent(irqEvent),
        .intPin(intPin), .reflStart(reflStart), .linkCtl(linkCtl),
        .mmdReq(mmdReq), .mmdRdata(mmdRdata));
    pcr_mdio_master u_pcr_mdio_master (
        .mclk(mclk), .mdioOut(mdioOut), .mdioOen(mdioOen), .mdc(mdc),
        .mdioLine(mdioLine));
    // ------------------------------------------------------------
    // far side and bench tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] mdat(logic [15:0] ad, logic [4:0] sp);
        return ad ^ {sp, 11'h5A5};
    endfunction
    // answer a cycle after a read, toggle otherwise so stale data shows
    always @(posedge mclk) begin
        mmdRdata <= mmdReq.rd ? mdat(mmdReq.addr, mmdReq.space) : ~mmdRdata;
        if (mmdReq.rd || mmdReq.wr) begin
            nReq++;
            reqSp = mmdReq.space;
        end
        if (mmdReq.rd) rdAddr = mmdReq.addr;
        if (mmdReq.wr) wrAddr = mmdReq.addr;
        if (mmdReq.wr) wrData = mmdReq.wdata;
        nSoft += linkCtl.softRst;
        nRefl += reflStart;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regRd(logic [4:0] ra, logic [15:0] exp, string what);
        logic [15:0] d;
        u_pcr_mdio_master.frame(1'b1, ra, 16'h0000, d);
        cyc(2);
        check16(what, exp, d);
    endtask
    task automatic regWr(logic [4:0] ra, logic [15:0] wd);
        logic [15:0] d;
        u_pcr_mdio_master.frame(1'b0, ra, wd, d);
        cyc(2);
    endtask
    // one data access; stored address moves only on a hit
    task automatic access(logic w, logic [4:0] sp, logic [1:0] cm);
        logic h;
        int   n;
        h = sp == 5'h01 || (sp == 5'h1F && a <= 16'h04D1);
        n = nReq;
        if (w) regWr(5'h0E, ~a);
        else regRd(5'h0E, h ? mdat(a, sp) : 16'h0000, "data");
        check16("requests", {15'h0, h}, 16'(nReq - n));
        if (h) check16("space", {11'h0, sp}, {11'h0, reqSp});
        if (h) check16("address", a, w ? wrAddr : rdAddr);
        if (h && w) check16("write data", ~a, wrData);
        if (h && (cm == 2'b10 || (cm == 2'b11 && w))) a = a + 16'h0001;
    endtask
    task automatic dropLink(logic [15:0] n);
        linkUp = 1'b0;
        cyc(6);
        check16("refl starts", n, 16'(nRefl));
        linkUp = 1'b1;
        cyc(4);
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // watchdog, well beyond the fifty-odd frames of the run
    initial begin
        cyc(70000);
        n_errors++;
        end_of_test();
    end
    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(4);
        check16("strap", 16'h0001, {15'h0, linkCtl.enable});
        regRd(5'h09, 16'h3000, "cfg reset");
        regRd(5'h0D, 16'h0000, "cmd reset");
        regRd(5'h11, 16'h010B, "irq reset");
        regWr(5'h09, 16'hC100);
        check16("ctl", 16'h0009, {11'h0, linkCtl});
        check16("soft resets", 16'h0001, 16'(nSoft));
        regRd(5'h09, 16'h4100, "cfg");
        dropLink(16'h0001);
        regWr(5'h09, 16'h3000);
        check16("ctl", 16'h0006, {11'h0, linkCtl});
        dropLink(16'h0001);
        for (int k = 0; k < 5; k++) begin
            a = AD[k];
            regWr(5'h0D, {11'h0, SP[k]});
            regWr(5'h0E, a);
            regRd(5'h0E, SP[k] == 5'h02 ? 16'h0 : a, "addr");
            regWr(5'h0D, {CM[k], 9'h0, SP[k]});
            regRd(5'h0D, {CM[k], 9'h0, SP[k]}, "cmd");
            access(1'b0, SP[k], CM[k]);
            access(1'b1, SP[k], CM[k]);
            access(1'b0, SP[k], CM[k]);
        end
        regWr(5'h0D, 16'h0001);
        regRd(5'h0E, 16'h0010, "pma addr kept");
        irqEvent = 1'b1;
        cyc(3);
        check16("int pin", 16'h0000, {15'h0, intPin});
        regWr(5'h11, 16'h0103);
        check16("int pin", 16'h0001, {15'h0, intPin});
        irqEvent = 1'b0;
        cyc(3);
        check16("int pin", 16'h0000, {15'h0, intPin});
        regWr(5'h11, 16'h0107);
        regRd(5'h11, 16'h0107, "irq test");
        check16("int pin", 16'h0001, {15'h0, intPin});
        regWr(5'h11, 16'h0103);
        check16("int pin", 16'h0000, {15'h0, intPin});
        // second reset with the strap low: enable must follow the strap
        strap = 1'b0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(4);
        check16("strap", 16'h0000, {15'h0, linkCtl.enable});
        check16("int pin", 16'h0001, {15'h0, intPin});
        regRd(5'h09, 16'h2000, "cfg strap low");
        regRd(5'h11, 16'h010B, "irq reset");
        end_of_test();
    end
endmodule
